// ==== core/pdpwm_pkg.sv ====
package pdpwm_pkg;

    // Bus geometry: printed offsets are register indices, byte address is index times four
    localparam int          ADDR_W              = 18;
    localparam int          DATA_W              = 32;
    localparam logic [15:0] IDX_CLOCK_CONTROL   = 16'hFFD0;
    localparam logic [15:0] IDX_DUTY_UPPER_HALF = 16'hFFD1;
    localparam logic [15:0] IDX_DUTY_LOWER_HALF = 16'hFFD2;
    localparam logic [15:0] IDX_PORT_MODE_SEL   = 16'hFFD3;
    localparam logic [15:0] IDX_PWM_STATUS      = 16'hFFD4;

    localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL   = {IDX_CLOCK_CONTROL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DUTY_UPPER_HALF = {IDX_DUTY_UPPER_HALF, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DUTY_LOWER_HALF = {IDX_DUTY_LOWER_HALF, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PORT_MODE_SEL   = {IDX_PORT_MODE_SEL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PWM_STATUS      = {IDX_PWM_STATUS, 2'b00};

    // Field positions
    localparam int CLOCK_SELECT_BIT = 0;
    localparam int PORT_MODE_BIT    = 0;
    localparam int UPPER_W          = 6;
    localparam int LOWER_W          = 8;
    localparam int DUTY_W           = 14;
    localparam int SUB_IDX_W        = 6;   // 64 sub-pulses per period
    localparam int SUB_POS_W        = 8;   // 256 half input clocks per sub-pulse
    localparam int HIGH_W           = 9;

    // Values after reset and fixed read values
    localparam logic [7:0] RST_CLOCK_CONTROL   = 8'hFE;
    localparam logic [7:0] RST_DUTY_UPPER_HALF = 8'hC0;
    localparam logic [7:0] RST_DUTY_LOWER_HALF = 8'h00;
    localparam logic [7:0] READ_ALL_ONES       = 8'hFF;
    localparam logic       RST_PORT_MODE       = 1'b0;

    // Duty value as two halves, upper on top
    typedef struct packed {
        logic [UPPER_W-1:0] upper;
        logic [LOWER_W-1:0] lower;
    } pdpwm_duty_t;

endpackage : pdpwm_pkg

// ==== core/pdpwm_core.sv ====
// Our own choice: register access over APB.
`timescale 1ns/10ps

module pdpwm_core (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [pdpwm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pdpwm_pkg::DATA_W-1:0] pwdata,
    output logic      [pdpwm_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Shared pin
    output logic                              pwmOut,
    output logic                              pwmPinSel
);
    import pdpwm_pkg::*;

    // Clock select state
    logic                 clkSel_q,    clkSel_d;
    // Port mode state
    logic                 portMode_q,  portMode_d;
    // Duty staging and transfer state
    pdpwm_duty_t          stage_q,     stage_d;
    pdpwm_duty_t          active_q,    active_d;
    logic                 pending_q,   pending_d;
    // Divider state
    logic                 divPhase_q,  divPhase_d;
    // Period counter state
    logic [DUTY_W-1:0]    halfCnt_q,   halfCnt_d;
    // Pin state
    logic                 pwmOut_q,    pwmOut_d;
    // Bus answer state
    logic [DATA_W-1:0]    prdata_q,    prdata_d;
    logic                 pready_q,    pready_d;
    logic                 pslverr_q,   pslverr_d;

    // Address decode and write strobes
    logic                 setupPhase;
    logic                 hitClock;
    logic                 hitUpper;
    logic                 hitLower;
    logic                 hitPort;
    logic                 hitStatus;
    logic                 hitAny;
    logic                 wrStrobe;
    logic                 wrClock;
    logic                 wrUpper;
    logic                 wrLower;
    logic                 wrPort;
    // Waveform helpers
    logic                 halfEn;
    logic                 periodEnd;
    logic                 transfer;
    logic [SUB_IDX_W-1:0] subIdx;
    logic [SUB_IDX_W-1:0] revIdx;
    logic [SUB_POS_W-1:0] subPos;
    logic [HIGH_W-1:0]    highLen;
    logic                 extraHigh;
    logic [DUTY_W-1:0]    dutyVal;
    // Read path
    logic [DATA_W-1:0]    statusWord;

    // Decode once; write and read paths share the same hits
    assign setupPhase = psel && !penable;
    assign hitClock   = (paddr == ADDR_CLOCK_CONTROL);
    assign hitUpper   = (paddr == ADDR_DUTY_UPPER_HALF);
    assign hitLower   = (paddr == ADDR_DUTY_LOWER_HALF);
    assign hitPort    = (paddr == ADDR_PORT_MODE_SEL);
    assign hitStatus  = (paddr == ADDR_PWM_STATUS);
    assign hitAny     = hitClock || hitUpper || hitLower || hitPort || hitStatus;

    // A write lands only at the edge that completes the access phase
    assign wrStrobe = psel && penable && pready_q && pwrite;
    assign wrClock  = wrStrobe && hitClock;
    assign wrUpper  = wrStrobe && hitUpper;
    assign wrLower  = wrStrobe && hitLower;
    assign wrPort   = wrStrobe && hitPort;

    // One enable per half input clock: every clock at /2, every other clock at /4
    assign halfEn    = clkSel_q ? divPhase_q : 1'b1;
    assign periodEnd = halfEn && (halfCnt_q == {DUTY_W{1'b1}});
    assign transfer  = periodEnd && pending_q;
    assign subIdx    = halfCnt_q[DUTY_W-1 -: SUB_IDX_W];
    assign subPos    = halfCnt_q[SUB_POS_W-1:0];
    assign dutyVal   = active_q;

    // Bit-reversed pulse index spreads the remainder over the period
    // so the extra half clocks never bunch up in one part of it
    always_comb begin
        for (int i = 0; i < SUB_IDX_W; i++) begin
            revIdx[i] = subIdx[SUB_IDX_W-1-i];
        end
    end

    // Each pulse is high for 1 + duty[13:6] half clocks, plus one on chosen pulses
    always_comb begin
        extraHigh = revIdx < dutyVal[SUB_IDX_W-1:0];
        highLen   = HIGH_W'(dutyVal[DUTY_W-1:SUB_IDX_W]) + HIGH_W'(1)
                  + HIGH_W'(extraHigh);
    end

    // Clock select: only bit 0 has a flop; reserved bits are constants on read
    // A rate change is not period-synced and bends the running period
    always_comb begin
        clkSel_d = clkSel_q;
        if (wrClock) begin
            clkSel_d = pwdata[CLOCK_SELECT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clkSel_q <= RST_CLOCK_CONTROL[CLOCK_SELECT_BIT];
        end else begin
            clkSel_q <= clkSel_d;
        end
    end

    // Port mode: hands the shared pin to the generator
    always_comb begin
        portMode_d = portMode_q;
        if (wrPort) begin
            portMode_d = pwdata[PORT_MODE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            portMode_q <= RST_PORT_MODE;
        end else begin
            portMode_q <= portMode_d;
        end
    end

    // Duty staging: halves collect here and never reach the waveform directly
    always_comb begin
        stage_d = stage_q;
        if (wrUpper) begin
            stage_d.upper = pwdata[UPPER_W-1:0];
        end
        if (wrLower) begin
            stage_d.lower = pwdata[LOWER_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= {RST_DUTY_UPPER_HALF[UPPER_W-1:0], RST_DUTY_LOWER_HALF};
        end else begin
            stage_q <= stage_d;
        end
    end

    // Transfer waits for the period boundary so a period never mixes two values
    // An upper write in the transfer cycle wins and waits for the next boundary
    always_comb begin
        active_d  = active_q;
        pending_d = pending_q;
        if (transfer) begin
            active_d  = stage_q;
            pending_d = 1'b0;
        end
        if (wrUpper) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active_q  <= {RST_DUTY_UPPER_HALF[UPPER_W-1:0], RST_DUTY_LOWER_HALF};
            pending_q <= 1'b0;
        end else begin
            active_q  <= active_d;
            pending_q <= pending_d;
        end
    end

    // Divider phase toggles freely; at /2 nothing looks at it
    always_comb begin
        divPhase_d = ~divPhase_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divPhase_q <= 1'b0;
        end else begin
            divPhase_q <= divPhase_d;
        end
    end

    // Period counter in half input clocks; it wraps at each period end
    always_comb begin
        halfCnt_d = halfCnt_q;
        if (halfEn) begin
            halfCnt_d = halfCnt_q + DUTY_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            halfCnt_q <= '0;
        end else begin
            halfCnt_q <= halfCnt_d;
        end
    end

    // Pulse compare is registered so the pin comes straight from a flop
    // Pin stays low unless the port mode hands it to the generator
    always_comb begin
        pwmOut_d = 1'b0;
        if (portMode_q) begin
            pwmOut_d = ({1'b0, subPos} < highLen);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwmOut_q <= 1'b0;
        end else begin
            pwmOut_q <= pwmOut_d;
        end
    end

    // Status word: sub-pulse index, transfer pending, clock select, active duty
    assign statusWord = DATA_W'({subIdx, pending_q, clkSel_q, active_q});

    // Zero-wait answer: ready stands for the one access cycle after setup
    always_comb begin
        pready_d = setupPhase;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    // Error only for unmapped addresses; the write path finds no hit there
    always_comb begin
        pslverr_d = setupPhase && !hitAny;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= pslverr_d;
        end
    end

    // Read data prepared in setup; write-only registers read as ones
    always_comb begin
        prdata_d = '0;
        if (setupPhase) begin
            if (hitClock) begin
                prdata_d = DATA_W'(READ_ALL_ONES);
            end else if (hitUpper || hitLower) begin
                prdata_d = DATA_W'(READ_ALL_ONES);
            end else if (hitPort) begin
                prdata_d = DATA_W'(portMode_q);
            end else if (hitStatus) begin
                prdata_d = statusWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= '0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // Outputs straight from flops
    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pwmOut    = pwmOut_q;
    assign pwmPinSel = portMode_q;

endmodule : pdpwm_core

// ==== testbench/pdpwm_core_asserts.sv ====
`timescale 1ns/10ps
module pdpwm_core_asserts (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // Bus and pin
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [pdpwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [pdpwm_pkg::DATA_W-1:0] prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         pwmOut,
    input wire logic                         pwmPinSel
);
    import pdpwm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read(a);
        pready && !pwrite && paddr == a;
    endsequence
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_ctrl_ones: assert property (s_read(ADDR_CLOCK_CONTROL) |-> prdata == 32'h000000FF)
        else $error("control read");
    a_upper_ones: assert property (s_read(ADDR_DUTY_UPPER_HALF) |-> prdata == 32'h000000FF)
        else $error("upper read");
    a_lower_ones: assert property (s_read(ADDR_DUTY_LOWER_HALF) |-> prdata == 32'h000000FF)
        else $error("lower read");
    a_pin_gated: assert property (!pwmPinSel && !$past(pwmPinSel) |-> !pwmOut)
        else $error("pin driven unselected");
    a_unmapped_err: assert property (pready && paddr == 18'h00000 |-> pslverr && prdata == 32'h0)
        else $error("unmapped accepted");
    a_mapped_ok: assert property (pready && paddr == ADDR_DUTY_LOWER_HALF |-> !pslverr)
        else $error("mapped refused");
endmodule : pdpwm_core_asserts
bind pdpwm_core pdpwm_core_asserts pdpwm_core_asserts_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmOut(pwmOut), .pwmPinSel(pwmPinSel));

// ==== testbench/pdpwm_filter.sv ====
`timescale 1ns/10ps
module pdpwm_filter (
    // Clock and window control
    input  wire logic        clk,
    input  wire logic        clear,
    // Pin and integrals
    input  wire logic        pwmOut,
    output logic      [31:0] highCnt,
    output logic      [31:0] riseCnt
);
    logic lastLevel;
    // Ideal integrator: counting cycles keeps the average exact
    always @(posedge clk) begin
        lastLevel <= pwmOut;
        highCnt <= clear ? 32'h0 : highCnt + {31'h0, pwmOut};
        riseCnt <= clear ? 32'h0 : riseCnt + {31'h0, pwmOut & ~lastLevel};
    end
endmodule : pdpwm_filter

// ==== testbench/pdpwm_bench.sv ====
`timescale 1ns/10ps
module pdpwm_bench;
    import pdpwm_pkg::*;
    logic              clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, clear = 0;
    logic [ADDR_W-1:0] paddr = 0;
    logic [DATA_W-1:0] pwdata = 0, prdata, rd;
    logic              pready, pslverr, pwmOut, pwmPinSel, err;
    logic [31:0]       highCnt, riseCnt;
    int                n_mismatch = 0, checks = 0, p;
    always #12.5 clk = ~clk;
    // Device and filter
    pdpwm_core pdpwm_core_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwmOut(pwmOut), .pwmPinSel(pwmPinSel));
    pdpwm_filter pdpwm_filter_i (.clk(clk), .clear(clear), .pwmOut(pwmOut),
        .highCnt(highCnt), .riseCnt(riseCnt));
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until ready is sampled high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Integrate over n whole cycles; a full period holds one rise per sub-pulse
    task automatic meas(input int n, input logic [31:0] expHigh);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        check("high time", highCnt, expHigh);
        check("pulses", riseCnt, (n >= 16384) ? 32'h40 : 32'h0);
    endtask : meas
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // Watchdog
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(0, ADDR_CLOCK_CONTROL, 0);
        check("control", rd, 32'hFF);
        apb(0, ADDR_DUTY_UPPER_HALF, 0);
        check("upper", rd, 32'hFF);
        apb(0, ADDR_DUTY_LOWER_HALF, 0);
        check("lower", rd, 32'hFF);
        apb(0, ADDR_PWM_STATUS, 0);
        check("reset state", rd & 32'h7FFF, 32'h0);
        apb(1, 18'h00000, 0);
        check("unmapped", {31'h0, err}, 32'h1);
        $display("test registers done");
        meas(64, 0);
        apb(1, ADDR_PORT_MODE_SEL, 32'h1);
        @(negedge clk);
        check("pin select", {31'h0, pwmPinSel}, 32'h1);
        meas(16384, 32'h40);
        $display("test default duty done");
        apb(1, ADDR_DUTY_LOWER_HALF, 32'h34);
        apb(0, ADDR_PWM_STATUS, 0);
        check("lower only", rd & 32'h3FFF, 32'h0);
        apb(1, ADDR_DUTY_UPPER_HALF, 32'h12);
        p = 0;
        do begin
            apb(0, ADDR_PWM_STATUS, 0);
            p++;
        end while (rd[15] === 1'b1 && p < 8000);
        check("new duty", rd & 32'h3FFF, 32'h1234);
        meas(16384, 32'h1274);
        $display("test duty update done");
        apb(1, ADDR_CLOCK_CONTROL, 32'h1);
        apb(0, ADDR_CLOCK_CONTROL, 0);
        check("control", rd, 32'hFF);
        meas(32768, 32'h24E8);
        $display("test slow clock done");
        conclude();
    end
endmodule : pdpwm_bench
